// file: src/fcc_defs.svh
// Offsets, fields, command bytes and timing figures of the card host
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define FCC_OFS_CMD 8'h00
`define FCC_OFS_ADDR 8'h04
`define FCC_OFS_WDATA 8'h08
`define FCC_OFS_RDATA 8'h0C
`define FCC_OFS_STAT 8'h10
// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define FCC_AW 25
`define FCC_CMD_OP_MSB 3
`define FCC_CMD_LANE_LSB 4
`define FCC_ST_BUSY 0
`define FCC_ST_REFUSED 1
`define FCC_ST_WINDOW 2
`define FCC_ST_SUSP 3
`define FCC_ST_IDENT 4
`define FCC_ST_PROTECT 5
`define FCC_ST_ERASING 6
`define FCC_ST_CARD_WIN 7
`define FCC_ST_TOGGLE 8
`define FCC_LANE_RST 2'h3
// ------------------------------------------------------------
// Operation codes written to the command register
// ------------------------------------------------------------
`define FCC_OP_READ 4'h0
`define FCC_OP_POLL 4'h1
`define FCC_OP_PROG 4'h2
`define FCC_OP_SERASE 4'h3
`define FCC_OP_ADDSEC 4'h4
`define FCC_OP_SUSP 4'h5
`define FCC_OP_RESUME 4'h6
`define FCC_OP_IDENT 4'h7
`define FCC_OP_RDRST 4'h8
`define FCC_OP_HWRST 4'h9
// ------------------------------------------------------------
// Command bytes and unlock addresses
// ------------------------------------------------------------
`define FCC_CB_UNL1 8'hAA
`define FCC_CB_UNL2 8'h55
`define FCC_CB_ERASE 8'h80
`define FCC_CB_SECTOR 8'h30
`define FCC_CB_SUSP 8'hB0
`define FCC_CB_RESUME 8'h30
`define FCC_CB_PROG 8'hA0
`define FCC_CB_IDENT 8'h90
`define FCC_CB_RDRST 8'hF0
`define FCC_CMA1 25'h000AAAA
`define FCC_CMA2 25'h0005555
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FCC_CLK_MHZ 200
`define FCC_T_STROBE_NS 150
`define FCC_T_RST_PULSE_NS 500
`define FCC_T_RST_READY_US 20
`define FCC_T_WIN_US 50
`define FCC_CYC_STROBE ((`FCC_T_STROBE_NS*`FCC_CLK_MHZ+999)/1000)
`define FCC_CYC_RST_PULSE ((`FCC_T_RST_PULSE_NS*`FCC_CLK_MHZ+999)/1000)
`define FCC_CYC_RST_READY (`FCC_T_RST_READY_US*`FCC_CLK_MHZ)
`define FCC_CYC_WIN (`FCC_T_WIN_US*`FCC_CLK_MHZ)
`endif

// file: src/fcc_pkg.sv
// Types shared by the card host modules
package fcc_pkg;
    typedef logic [24:0] fcc_addr_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CYC, ST_RST_HI, ST_RST_WAIT} fcc_st_e;
    typedef enum logic [1:0] {EN_IDLE, EN_SET, EN_STB, EN_HOLD} fcc_eng_e;
    typedef struct packed {
        logic last;
        logic wr;
        logic use_wdata;
        fcc_addr_t addr;
        logic [7:0] dat;
    } fcc_step_s;
endpackage : fcc_pkg

// file: src/fcc_cyc_if.sv
// Request and answer between sequencer and card bus cycle engine
`timescale 1ns/1ps
interface fcc_cyc_if;
    logic req;
    logic wr;
    logic [24:0] addr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    logic ack;
    logic [15:0] rdata;
    modport mst (output req, wr, addr, wdata, lanes, input ack, rdata);
    modport eng (input req, wr, addr, wdata, lanes, output ack, rdata);
endinterface : fcc_cyc_if

// file: src/fcc_cyc_eng.sv
// One card bus cycle: card enables, strobes, address and data pins
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_cyc_eng #(
    parameter int STROBE_CYC = `FCC_CYC_STROBE
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Sequencer side
    fcc_cyc_if.eng cyc,
    // Card pins
    output logic card_ce1_n,
    output logic card_ce2_n,
    output logic card_oe_n,
    output logic card_we_n,
    output logic [24:0] card_addr,
    output logic [15:0] card_data_o,
    output logic [15:0] card_data_oe,
    input wire logic [15:0] card_data_i
);
    import fcc_pkg::*;

    fcc_eng_e st_ff, nxt_st;
    logic [7:0] cnt_ff;
    logic [24:0] addr_ff;
    logic [15:0] rdata_ff;
    logic [15:0] wdata_ff;
    logic [1:0] lanes_ff;
    logic wr_ff;
    logic active;
    logic strobe;
    logic stb_done;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    assign active = (st_ff != EN_IDLE);
    assign strobe = (st_ff == EN_STB);
    assign stb_done = strobe && (cnt_ff == 8'(STROBE_CYC - 1));
    assign cyc.ack = (st_ff == EN_HOLD);
    assign cyc.rdata = rdata_ff;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            EN_IDLE: if (cyc.req) nxt_st = EN_SET;
            EN_SET: nxt_st = EN_STB;
            EN_STB: if (stb_done) nxt_st = EN_HOLD;
            default: nxt_st = EN_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= EN_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= strobe ? cnt_ff + 8'h01 : 8'h00;
        end
    end

    // Request copied once so the pins stay steady for the whole cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_ff <= 25'h0000000;
            wdata_ff <= 16'h0000;
            lanes_ff <= 2'h0;
            wr_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            if (st_ff == EN_IDLE && cyc.req) begin
                addr_ff <= cyc.addr;
                wdata_ff <= cyc.wdata;
                lanes_ff <= cyc.lanes;
                wr_ff <= cyc.wr;
            end
            if (stb_done && !wr_ff) rdata_ff <= card_data_i;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // Both enables high between cycles: card in standby
    assign card_ce1_n = !(active && lanes_ff[0]);
    assign card_ce2_n = !(active && lanes_ff[1]);
    // Address is steady a cycle before we falls, data a cycle past rise
    assign card_we_n = !(strobe && wr_ff);
    assign card_oe_n = !(strobe && !wr_ff);
    assign card_addr = addr_ff;
    assign card_data_o = wdata_ff;
    assign card_data_oe = {{8{active && wr_ff && lanes_ff[1]}},
                           {8{active && wr_ff && lanes_ff[0]}}};
endmodule : fcc_cyc_eng

// file: src/fcc_host.sv
// Flash card host: Wishbone registers and command sequencer
`timescale 1ns/1ps
`include "fcc_defs.svh"
// Overview of operation
// - Sector erase is six writes, last one carrying the sector address.
// - Extra sectors join by 30H only within 50 us of the last.
// - Completion polling reads an address inside an erasing sector.
// - 90H enters identifier read until a read/reset command.
// - Reset pin high at least 500 ns; card ready 20 us later.
module fcc_host #(
    parameter int WIN_CYC = `FCC_CYC_WIN,
    parameter int RST_PULSE_CYC = `FCC_CYC_RST_PULSE,
    parameter int RST_READY_CYC = `FCC_CYC_RST_READY
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Card pins
    output logic card_reset,
    output logic card_ce1_n,
    output logic card_ce2_n,
    output logic card_oe_n,
    output logic card_we_n,
    output logic card_reg_n,
    output logic [24:0] card_addr,
    output logic [15:0] card_data_o,
    output logic [15:0] card_data_oe,
    input wire logic [15:0] card_data_i,
    input wire logic card_protect_i
);
    import fcc_pkg::*;

    fcc_cyc_if cyc ();

    fcc_st_e st_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [3:0] op_ff;
    logic [1:0] lanes_ff;
    logic [2:0] step_ff;
    fcc_addr_t addr_ff;
    fcc_addr_t sec_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic [15:0] prev_ff;
    logic [15:0] win_ff;
    logic [15:0] rcnt_ff;
    logic refused_ff;
    logic susp_ff;
    logic ident_ff;
    logic erasing_ff;
    logic req_ff;
    fcc_step_s step;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire bus_wr = bus_req && wb_we_i && ack_ff;
    wire sel_cmd = (wb_adr_i == `FCC_OFS_CMD);
    wire sel_addr = (wb_adr_i == `FCC_OFS_ADDR);
    wire sel_wdata = (wb_adr_i == `FCC_OFS_WDATA);
    wire sel_rdata = (wb_adr_i == `FCC_OFS_RDATA);
    wire sel_stat = (wb_adr_i == `FCC_OFS_STAT);
    wire [3:0] new_op = wb_dat_i[`FCC_CMD_OP_MSB:0];
    wire [1:0] new_lanes = wb_dat_i[`FCC_CMD_LANE_LSB+1:`FCC_CMD_LANE_LSB];
    wire cmd_wr = bus_wr && sel_cmd && wb_sel_i[0];
    wire busy = (st_ff != ST_IDLE);
    wire win_open = (win_ff != 16'h0000);
    wire is_read = (new_op == `FCC_OP_READ) || (new_op == `FCC_OP_POLL);
    wire is_card_wr = !is_read && (new_op != `FCC_OP_HWRST);

    // ------------------------------------------------------------
    // Acceptance of an operation
    // ------------------------------------------------------------
    wire bad_op = (new_op > `FCC_OP_HWRST);
    wire bad_prot = is_card_wr && card_protect_i;
    wire bad_add = (new_op == `FCC_OP_ADDSEC) && !win_open;
    wire bad_susp = (new_op == `FCC_OP_SUSP)
                    && !(erasing_ff && !susp_ff);
    wire bad_res = (new_op == `FCC_OP_RESUME) && !susp_ff;
    // Card would ignore these while it erases, so do not send them
    wire bad_busy = erasing_ff && !susp_ff && !win_open
                    && ((new_op == `FCC_OP_PROG)
                    || (new_op == `FCC_OP_SERASE)
                    || (new_op == `FCC_OP_IDENT));
    wire bad_poll = (new_op == `FCC_OP_POLL) && !erasing_ff;
    wire refuse = busy || bad_op || bad_prot || bad_add || bad_susp
                  || bad_res || bad_busy || bad_poll;
    wire start = cmd_wr && !refuse;
    wire last_ack = (st_ff == ST_CYC) && cyc.ack && step.last;

    // ------------------------------------------------------------
    // Step table of each command sequence
    // ------------------------------------------------------------
    function automatic fcc_step_s step_of(input logic [3:0] op,
                                          input logic [2:0] s,
                                          input fcc_addr_t a,
                                          input fcc_addr_t sa);
        fcc_step_s r;
        r = '{last: 1'b1, wr: 1'b1, use_wdata: 1'b0, addr: a,
              dat: `FCC_CB_RDRST};
        if (op == `FCC_OP_READ) begin
            r.wr = 1'b0;
        end else if (op == `FCC_OP_POLL) begin
            r.wr = 1'b0;
            r.addr = sa;
        end else if (s == 3'h0 && op != `FCC_OP_SUSP
                     && op != `FCC_OP_RESUME && op != `FCC_OP_RDRST
                     && op != `FCC_OP_ADDSEC) begin
            r = '{1'b0, 1'b1, 1'b0, `FCC_CMA1, `FCC_CB_UNL1};
        end else if (op == `FCC_OP_SUSP) begin
            r.dat = `FCC_CB_SUSP;
        end else if (op == `FCC_OP_RESUME) begin
            r.dat = `FCC_CB_RESUME;
        end else if (op == `FCC_OP_ADDSEC) begin
            r.dat = `FCC_CB_SECTOR;
        end else if (s == 3'h1 || s == 3'h4) begin
            r = '{1'b0, 1'b1, 1'b0, `FCC_CMA2, `FCC_CB_UNL2};
        end else if (s == 3'h3) begin
            r = '{1'b0, 1'b1, 1'b0, `FCC_CMA1, `FCC_CB_UNL1};
        end else if (op == `FCC_OP_PROG) begin
            r = '{(s == 3'h3), 1'b1, (s == 3'h3), (s == 3'h3) ? a
                  : `FCC_CMA1, `FCC_CB_PROG};
        end else if (op == `FCC_OP_IDENT) begin
            r = '{1'b1, 1'b1, 1'b0, `FCC_CMA1, `FCC_CB_IDENT};
        end else if (s == 3'h2) begin
            r = '{1'b0, 1'b1, 1'b0, `FCC_CMA1, `FCC_CB_ERASE};
        end else if (op != `FCC_OP_RDRST) begin
            r.dat = `FCC_CB_SECTOR;
        end
        if (op == `FCC_OP_PROG && s == 3'h3) begin
            r.last = 1'b1;
            r.use_wdata = 1'b1;
            r.addr = a;
        end
        return r;
    endfunction : step_of

    assign step = step_of(op_ff, step_ff, addr_ff, sec_ff);
    assign cyc.req = req_ff;
    assign cyc.wr = step.wr;
    assign cyc.addr = step.addr;
    assign cyc.wdata = step.use_wdata ? wdata_ff : {step.dat, step.dat};
    assign cyc.lanes = lanes_ff;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= ST_IDLE;
            step_ff <= 3'h0;
            req_ff <= 1'b0;
            rcnt_ff <= 16'h0000;
        end else begin
            case (st_ff)
                ST_IDLE: if (start) begin
                    step_ff <= 3'h0;
                    rcnt_ff <= 16'h0000;
                    req_ff <= (new_op != `FCC_OP_HWRST);
                    st_ff <= (new_op == `FCC_OP_HWRST) ? ST_RST_HI : ST_CYC;
                end
                ST_CYC: if (cyc.ack) begin
                    step_ff <= step_ff + 3'h1;
                    req_ff <= !step.last;
                    if (step.last) st_ff <= ST_IDLE;
                end
                ST_RST_HI: begin
                    rcnt_ff <= rcnt_ff + 16'h0001;
                    if (rcnt_ff == 16'(RST_PULSE_CYC - 1)) begin
                        rcnt_ff <= 16'h0000;
                        st_ff <= ST_RST_WAIT;
                    end
                end
                default: begin
                    // Covers the 20 us ready time that follows the 500 ns reset pulse
                    rcnt_ff <= rcnt_ff + 16'h0001;
                    if (rcnt_ff == 16'(RST_READY_CYC - 1))
                        st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Host view of card mode
    // ------------------------------------------------------------
    wire hw_rst = (st_ff == ST_RST_HI);
    wire win_load = last_ack && ((op_ff == `FCC_OP_SERASE)
                    || (op_ff == `FCC_OP_ADDSEC));
    wire win_kill = hw_rst || (start && is_card_wr
                    && new_op != `FCC_OP_ADDSEC);
    wire clr_erasing = bus_wr && sel_stat && wb_dat_i[`FCC_ST_ERASING];
    wire clr_refused = bus_wr && sel_stat && wb_dat_i[`FCC_ST_REFUSED];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            win_ff <= 16'h0000;
        end else if (win_load) begin
            win_ff <= 16'(WIN_CYC);
        end else if (win_kill) begin
            win_ff <= 16'h0000;
        end else if (win_open) begin
            win_ff <= win_ff - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            susp_ff <= 1'b0;
            ident_ff <= 1'b0;
            erasing_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            // Reset aborts everything; erased sectors may be damaged
            if (hw_rst) begin
                susp_ff <= 1'b0;
                ident_ff <= 1'b0;
                erasing_ff <= 1'b0;
            end else if (last_ack) begin
                if (op_ff == `FCC_OP_SUSP) susp_ff <= 1'b1;
                if (op_ff == `FCC_OP_RESUME) susp_ff <= 1'b0;
                if (op_ff == `FCC_OP_IDENT) ident_ff <= 1'b1;
                if (op_ff == `FCC_OP_RDRST) ident_ff <= 1'b0;
                if (op_ff == `FCC_OP_SERASE) erasing_ff <= 1'b1;
            end else if (clr_erasing && !susp_ff) begin
                erasing_ff <= 1'b0;
            end
            // Set wins over clear
            if (cmd_wr && refuse) refused_ff <= 1'b1;
            else if (clr_refused) refused_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op_ff <= `FCC_OP_READ;
            lanes_ff <= `FCC_LANE_RST;
            addr_ff <= 25'h0000000;
            sec_ff <= 25'h0000000;
            wdata_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            prev_ff <= 16'h0000;
        end else begin
            if (start) op_ff <= new_op;
            if (start) lanes_ff <= (new_lanes == 2'h0) ? `FCC_LANE_RST
                                                       : new_lanes;
            if (start && new_op == `FCC_OP_SERASE) sec_ff <= addr_ff;
            if (bus_wr && sel_addr && !busy) addr_ff <= wb_dat_i[24:0];
            if (bus_wr && sel_wdata && !busy) wdata_ff <= wb_dat_i[15:0];
            if (last_ack && !step.wr) begin
                prev_ff <= rdata_ff;
                rdata_ff <= cyc.rdata;
            end
        end
    end

    wire [15:0] tog = rdata_ff ^ prev_ff;
    wire [15:0] stat = {7'h00,
        tog[2] || tog[10],
        rdata_ff[3] || rdata_ff[11],
        erasing_ff, card_protect_i, ident_ff, susp_ff, win_open,
        refused_ff, busy};
    wire [31:0] rd_mux = sel_cmd ? {26'h0, lanes_ff, op_ff}
                       : sel_addr ? {7'h00, addr_ff}
                       : sel_wdata ? {16'h0000, wdata_ff}
                       : sel_rdata ? {16'h0000, rdata_ff}
                       : sel_stat ? {16'h0000, stat}
                       : 32'h00000000;

    // Ack one cycle after the request, dropped in the next
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= bus_req && !ack_ff;
            dat_ff <= rd_mux;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign card_reset = hw_rst;
    assign card_reg_n = 1'b1;

    fcc_cyc_eng u_eng (
        .clk_sys(clk_sys),
        .rst(rst),
        .cyc(cyc),
        .card_ce1_n(card_ce1_n),
        .card_ce2_n(card_ce2_n),
        .card_oe_n(card_oe_n),
        .card_we_n(card_we_n),
        .card_addr(card_addr),
        .card_data_o(card_data_o),
        .card_data_oe(card_data_oe),
        .card_data_i(card_data_i)
    );
endmodule : fcc_host

// file: verification/fcc_host_assertions.sv
// Checker on the card host ports, bound into the host
`timescale 1ns/1ps
module fcc_host_checker #(parameter int RST_PULSE_CYC = 100) (
    // Clock, reset and bus handshake
    input wire logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_ack_o,
    // Card pins
    input wire logic card_reset, card_ce1_n, card_ce2_n, card_oe_n,
    input wire logic card_we_n, card_reg_n, card_protect_i,
    input wire logic [24:0] card_addr,
    input wire logic [15:0] card_data_oe
);
    int rst_cnt_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------
    // Reset pulse length
    // ----------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) rst_cnt_ff <= 0;
        else rst_cnt_ff <= card_reset ? rst_cnt_ff + 1 : 0;
    end
    sequence s_we_low;
        !card_we_n [*8];
    endsequence
    ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    reg_tie_a: assert property (card_reg_n)
        else $error("attribute select driven");
    rst_float_a: assert property (card_reset |-> card_ce1_n && card_ce2_n && card_data_oe == 16'h0000)
        else $error("card accessed during reset");
    standby_a: assert property (card_ce1_n && card_ce2_n |-> card_data_oe == 16'h0000)
        else $error("data driven in standby");
    strobe_len_a: assert property ($fell(card_we_n) |-> s_we_low ##23 $rose(card_we_n))
        else $error("write strobe length wrong");
    addr_hold_a: assert property (!card_we_n && !$fell(card_we_n) |-> $stable(card_addr))
        else $error("address moved under strobe");
    prot_write_a: assert property ($fell(card_we_n) |-> !card_protect_i)
        else $error("write while protected");
    // Shortest legal card reset pulse, 500 ns in 5 ns cycles
    rst_pulse_a: assert property ($fell(card_reset) |-> rst_cnt_ff >= RST_PULSE_CYC)
        else $error("card reset pulse length wrong");
endmodule : fcc_host_checker
bind fcc_host fcc_host_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .card_reset(card_reset),
    .card_ce1_n(card_ce1_n), .card_ce2_n(card_ce2_n),
    .card_oe_n(card_oe_n), .card_we_n(card_we_n),
    .card_reg_n(card_reg_n), .card_protect_i(card_protect_i),
    .card_addr(card_addr), .card_data_oe(card_data_oe));

// file: verification/fcc_card_model.sv
// Behavioural flash card answering the host's card pins
`timescale 1ns/1ps
module fcc_card_model #(
    parameter realtime WIN_NS = 1000.0,
    parameter logic [15:0] MAKER = 16'h1111,
    parameter logic [15:0] DEVICE = 16'h2222
) (
    // Card pins
    input wire logic card_reset, card_ce1_n, card_ce2_n, card_oe_n,
    input wire logic card_we_n,
    input wire logic [24:0] card_addr,
    input wire logic [15:0] card_data_o, card_data_oe,
    output logic [15:0] card_data_i,
    // Protect switch, supply lockout and protect status pin
    input wire logic protect_switch, supply_low,
    output logic card_protect_i
);
    logic [1:0] mode = 2'h0; // Read, identifier, erase, suspended
    logic [24:0] a_lat = '0;
    logic [39:0] hist = '0;
    logic [255:0] esec = '0;
    logic [15:0] last = 16'h0000;
    logic [7:0] d;
    logic tgl = 1'b0;
    realtime t30 = 0.0;
    // ----------------
    // Pins and commands
    // ----------------
    assign card_protect_i = protect_switch;
    // Released bus shows the inverse, never a stale value
    assign card_data_i = (card_reset || card_oe_n || (card_ce1_n && card_ce2_n))
        ? ~last : last;
    function automatic logic win();
        return mode == 2'h2 && $realtime - t30 < WIN_NS;
    endfunction : win
    always @(negedge card_we_n) a_lat = card_addr;
    always @(posedge card_reset or posedge supply_low) begin
        mode = 2'h0;
        esec = '0;
    end
    // Erase runs on unseen and never ends here
    always @(posedge card_we_n) begin
        d = card_data_oe[0] ? card_data_o[7:0] : card_data_o[15:8];
        if (!card_reset && !protect_switch && !supply_low) begin
            if (mode == 2'h2 && d == 8'hB0) mode = 2'h3;
            else if (mode == 2'h2 && d == 8'h30 && win()) begin
                esec[a_lat[24:17]] = 1'b1;
                t30 = $realtime;
            end else if (mode == 2'h2) begin
                if (win()) mode = 2'h0;
            end else if (mode == 2'h3) begin
                if (d == 8'h30) t30 = $realtime - WIN_NS;
                if (d == 8'h30) mode = 2'h2;
            end else if ({hist, d} == 48'hAA5580AA5530) begin
                mode = 2'h2;
                esec[a_lat[24:17]] = 1'b1;
                t30 = $realtime;
            end else if (hist[15:0] == 16'hAA55 && d == 8'h90) mode = 2'h1;
            else if (d == 8'hF0) mode = 2'h0;
            hist = {hist[31:0], d};
        end
    end
    always @(negedge card_oe_n) begin
        if (mode == 2'h1) last = card_addr[0] ? DEVICE : MAKER;
        else if (win()) last = 16'h0808;
        else if (mode[1] && esec[card_addr[24:17]]) begin
            tgl = ~tgl;
            last = tgl ? 16'h0404 : 16'h0000;
        end else last = card_addr[15:0] ^ 16'h5A5A;
    end
endmodule : fcc_card_model

// file: verification/fcc_host_bench.sv
// Self-checking bench of the card host against the card model
`timescale 1ns/1ps
`include "fcc_defs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
$display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module fcc_host_bench;
    localparam logic [15:0] ID_MK = 16'h1111; // Arbitrary value
    localparam logic [15:0] ID_DV = 16'h2222; // Arbitrary value
    logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, prot = 0, low = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, q, wb_dat_o;
    logic wb_ack_o, card_reset, ce1_n, ce2_n, oe_n, we_n, reg_n, wp;
    logic [24:0] card_addr;
    logic [15:0] d_o, d_oe, d_i;
    int n_fail = 0, check_count = 0;
    fcc_host #(.WIN_CYC(200)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .card_reset(card_reset),
        .card_ce1_n(ce1_n), .card_ce2_n(ce2_n), .card_oe_n(oe_n),
        .card_we_n(we_n), .card_reg_n(reg_n), .card_addr(card_addr),
        .card_data_o(d_o), .card_data_oe(d_oe), .card_data_i(d_i),
        .card_protect_i(wp));
    fcc_card_model #(.MAKER(ID_MK), .DEVICE(ID_DV)) u_card (
        .card_reset(card_reset), .card_ce1_n(ce1_n), .card_ce2_n(ce2_n),
        .card_oe_n(oe_n), .card_we_n(we_n), .card_addr(card_addr),
        .card_data_o(d_o), .card_data_oe(d_oe), .card_data_i(d_i),
        .protect_switch(prot), .supply_low(low), .card_protect_i(wp));
    // ----------------
    // Bus tasks
    // ----------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // Word lanes; polls busy so the card sequence has ended
    task automatic op(input logic [3:0] o);
        wb(1'b1, `FCC_OFS_CMD, {24'h0, 4'h3, o});
        do wb(1'b0, `FCC_OFS_STAT, 32'h0); while (q[`FCC_ST_BUSY] !== 1'b0);
    endtask : op
    task automatic chk(input logic [7:0] a, input logic [31:0] m, e);
        wb(1'b0, a, 32'h0);
        `CHK(q & m, e)
    endtask : chk
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial forever #2.5 clk_sys = ~clk_sys;
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        conclude;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        chk(`FCC_OFS_STAT, 32'h1FF, 32'h0);
        chk(8'h40, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, `FCC_OFS_ADDR, 32'h124);
        op(`FCC_OP_READ);
        chk(`FCC_OFS_RDATA, 32'hFFFF, 32'h124 ^ 32'h5A5A);
        wb(1'b1, `FCC_OFS_ADDR, 32'h0);
        op(`FCC_OP_IDENT);
        chk(`FCC_OFS_STAT, 32'h10, 32'h10);
        op(`FCC_OP_READ);
        chk(`FCC_OFS_RDATA, 32'hFFFF, {16'h0, ID_MK});
        wb(1'b1, `FCC_OFS_ADDR, 32'h1);
        op(`FCC_OP_READ);
        chk(`FCC_OFS_RDATA, 32'hFFFF, {16'h0, ID_DV});
        op(`FCC_OP_RDRST);
        op(`FCC_OP_READ);
        chk(`FCC_OFS_RDATA, 32'hFFFF, 32'h1 ^ 32'h5A5A);
        $display("Step 1 finished");
        wb(1'b1, `FCC_OFS_ADDR, 32'h20000);
        op(`FCC_OP_SERASE);
        chk(`FCC_OFS_STAT, 32'h47, 32'h44);
        op(`FCC_OP_READ);
        chk(`FCC_OFS_STAT, 32'h80, 32'h80);
        wb(1'b1, `FCC_OFS_ADDR, 32'h40000);
        op(`FCC_OP_ADDSEC);
        chk(`FCC_OFS_STAT, 32'h2, 32'h0);
        repeat (300) @(posedge clk_sys);
        op(`FCC_OP_ADDSEC);
        chk(`FCC_OFS_STAT, 32'h6, 32'h2);
        wb(1'b1, `FCC_OFS_STAT, 32'h2);
        op(`FCC_OP_POLL);
        op(`FCC_OP_POLL);
        chk(`FCC_OFS_STAT, 32'h100, 32'h100);
        $display("Step 2 finished");
        op(`FCC_OP_SUSP);
        chk(`FCC_OFS_STAT, 32'hA, 32'h8);
        wb(1'b1, `FCC_OFS_ADDR, 32'h60000);
        wb(1'b1, `FCC_OFS_WDATA, 32'hFF);
        op(`FCC_OP_PROG);
        chk(`FCC_OFS_STAT, 32'h2, 32'h0);
        op(`FCC_OP_RESUME);
        chk(`FCC_OFS_STAT, 32'hA, 32'h0);
        op(`FCC_OP_RESUME);
        chk(`FCC_OFS_STAT, 32'h2, 32'h2);
        wb(1'b1, `FCC_OFS_STAT, 32'h42);
        $display("Step 3 finished");
        op(`FCC_OP_HWRST);
        wb(1'b1, `FCC_OFS_ADDR, 32'h124);
        op(`FCC_OP_READ);
        chk(`FCC_OFS_RDATA, 32'hFFFF, 32'h124 ^ 32'h5A5A);
        prot <= 1'b1;
        repeat (4) @(posedge clk_sys);
        op(`FCC_OP_PROG);
        chk(`FCC_OFS_STAT, 32'h22, 32'h22);
        prot <= 1'b0;
        low <= 1'b1;
        op(`FCC_OP_IDENT);
        low <= 1'b0;
        op(`FCC_OP_READ);
        chk(`FCC_OFS_RDATA, 32'hFFFF, 32'h124 ^ 32'h5A5A);
        $display("Step 4 finished");
        conclude;
    end
endmodule : fcc_host_bench
